//--- prt_board_model.sv
// Board side of the port pins: resolves each pad from the driver and pull-up.
// Assumes undriven, unpulled pins take the level the bench chooses in ext_lvl.
`timescale 1ns/1ps
module prt_board_model (
    input wire [127:0] pin_out,
    input wire [127:0] pin_oe_n,
    input wire [127:0] pin_pullup_en,
    input wire [127:0] ext_lvl,
    output wire [127:0] pin_in
);
// Driven pads show the driver, released pads the pull-up or the outside level
assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pullup_en | ext_lvl));
endmodule

//--- prt_pin_cell.v
// One 8-bit port slot: turns the stored settings into pad controls.
// Assumes settings already masked to the bits that exist in this slot.
`timescale 1ns/1ps
module prt_pin_cell #(
    parameter [7:0] IO_M = 8'h00,
    parameter [7:0] OUT_M = 8'h00,
    parameter [7:0] PULL_M = 8'h00,
    parameter [7:0] TTL_M = 8'h00,
    parameter [7:0] ODRN_M = 8'h00
) (
    input wire [7:0] data,
    input wire [7:0] mode,
    input wire [7:0] pull,
    input wire [7:0] ttl,
    input wire [7:0] odrn,
    input wire [7:0] ana,
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe_n,
    output wire [7:0] pullup_en,
    output wire [7:0] ttl_en,
    output wire [7:0] analog_en
);
    wire [7:0] drive;
    wire [7:0] is_input;

    // An analog pin never drives; output-only bits always drive
    assign drive = ((IO_M & ~mode) | OUT_M) & ~ana;
    assign is_input = IO_M & mode;
    // Open drain pulls low only, releases the pad for a one
    assign pad_oe_n = ~(drive & ~(ODRN_M & odrn & data));
    assign pad_out = data & ~(ODRN_M & odrn);
    assign pullup_en = PULL_M & pull & is_input & ~ana;
    assign ttl_en = TTL_M & ttl;
    assign analog_en = ana;
endmodule

//--- prt_port_cfg.v
// Port pin configuration for the 80-pin variant, with an AXI4-Lite slave.
// Assumes pins are sampled synchronous to aclk; pad drivers sit outside.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "prt_regs.vh"
module prt_port_cfg (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [127:0] pin_in,
    output wire [127:0] pin_out,
    output wire [127:0] pin_oe_n,
    output wire [127:0] pin_pullup_en,
    output wire [127:0] pin_ttl_en,
    output wire [127:0] pin_analog_en,
    input wire reset_pin_n,
    output wire ext_reset_req,
    output wire [7:0] redirect_sel
);
    localparam [127:0] IO_M = `PRT_IO_MASK;
    localparam [127:0] IN_M = `PRT_IN_MASK;
    localparam [127:0] OUT_M = `PRT_OUT_MASK;
    localparam [127:0] PULL_M = `PRT_PULL_MASK;
    localparam [127:0] TTL_M = `PRT_TTL_MASK;
    localparam [127:0] ODRN_M = `PRT_ODRN_MASK;
    localparam [127:0] ASEL_M = `PRT_ASEL_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Storage

    reg [127:0] data_reg;
    reg [127:0] mode_reg;
    reg [127:0] pull_reg;
    reg [127:0] ttl_reg;
    reg [127:0] odrn_reg;
    reg [127:0] pin_digital_analog_select_reg;
    reg [11:0] converter_pin_config_reg;
    reg [7:0] peripheral_pin_redirect_reg;
    reg ext_reset_reg;

    reg aw_hold_reg;
    reg w_hold_reg;
    reg [11:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function map_ok;
        input [11:0] a;
        reg [3:0] s;
        reg [2:0] k;
        begin
            s = a[5:2];
            k = a[8:6];
            map_ok = 1'b0;
            if (a[11:9] != 3'h0 || a[1:0] != 2'h0) begin
                map_ok = 1'b0;
            end else if (k == `PRT_KIND_DATA) begin
                map_ok = |(IO_M[s*8+:8] | OUT_M[s*8+:8]);
            end else if (k == `PRT_KIND_MODE) begin
                map_ok = |IO_M[s*8+:8];
            end else if (k == `PRT_KIND_PULL) begin
                map_ok = |PULL_M[s*8+:8];
            end else if (k == `PRT_KIND_TTL) begin
                map_ok = |TTL_M[s*8+:8];
            end else if (k == `PRT_KIND_ODRN) begin
                map_ok = |ODRN_M[s*8+:8];
            end else if (k == `PRT_KIND_ASEL) begin
                map_ok = |ASEL_M[s*8+:8];
            end else if (k == `PRT_KIND_MISC) begin
                map_ok = (s == `PRT_MISC_CONV) || (s == `PRT_MISC_REDIR) ||
                    (s == `PRT_MISC_STAT);
            end else begin
                map_ok = |(IO_M[s*8+:8] | IN_M[s*8+:8] | OUT_M[s*8+:8]);
            end
        end
    endfunction

    function [31:0] rd_val;
        input [11:0] a;
        reg [3:0] s;
        reg [2:0] k;
        begin
            s = a[5:2];
            k = a[8:6];
            rd_val = 32'h0000_0000;
            if (k == `PRT_KIND_DATA) begin
                rd_val[7:0] = data_reg[s*8+:8];
            end else if (k == `PRT_KIND_MODE) begin
                rd_val[7:0] = mode_reg[s*8+:8];
            end else if (k == `PRT_KIND_PULL) begin
                rd_val[7:0] = pull_reg[s*8+:8];
            end else if (k == `PRT_KIND_TTL) begin
                rd_val[7:0] = ttl_reg[s*8+:8];
            end else if (k == `PRT_KIND_ODRN) begin
                rd_val[7:0] = odrn_reg[s*8+:8];
            end else if (k == `PRT_KIND_ASEL) begin
                rd_val[7:0] = pin_digital_analog_select_reg[s*8+:8];
            end else if (k == `PRT_KIND_MISC) begin
                if (s == `PRT_MISC_CONV) begin
                    rd_val[11:0] = converter_pin_config_reg;
                end else if (s == `PRT_MISC_REDIR) begin
                    rd_val[7:0] = peripheral_pin_redirect_reg;
                end else begin
                    rd_val[0] = ext_reset_reg;
                end
            end else begin
                // Live pin level, only bits that exist in the slot
                rd_val[7:0] = pin_in[s*8+:8] &
                    (IO_M[s*8+:8] | IN_M[s*8+:8] | OUT_M[s*8+:8]);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel

    wire aw_take;
    wire w_take;
    wire wr_go;
    wire wr_ok;
    wire [3:0] wr_slot;
    wire [2:0] wr_kind;
    wire [7:0] wb0;
    wire [3:0] wb1;

    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_ok = map_ok(awaddr_reg);
    assign wr_slot = awaddr_reg[5:2];
    assign wr_kind = awaddr_reg[8:6];
    assign wb0 = wdata_reg[7:0];
    assign wb1 = wdata_reg[11:8];
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `PRT_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `PRT_RESP_OKAY : `PRT_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Unimplemented bits are masked on write so they always read zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= 128'h0;
            mode_reg <= IO_M;
            pull_reg <= 128'h0;
            ttl_reg <= 128'h0;
            odrn_reg <= 128'h0;
            pin_digital_analog_select_reg <= ASEL_M;
            converter_pin_config_reg <= `PRT_CONV_RESET;
            peripheral_pin_redirect_reg <= `PRT_REDIR_RESET;
        end else if (wr_go && wr_ok && wstrb_reg[0]) begin
            if (wr_kind == `PRT_KIND_DATA) begin
                data_reg[wr_slot*8+:8] <= wb0 & (IO_M[wr_slot*8+:8] | OUT_M[wr_slot*8+:8]);
            end else if (wr_kind == `PRT_KIND_MODE) begin
                mode_reg[wr_slot*8+:8] <= wb0 & IO_M[wr_slot*8+:8];
            end else if (wr_kind == `PRT_KIND_PULL) begin
                pull_reg[wr_slot*8+:8] <= wb0 & PULL_M[wr_slot*8+:8];
            end else if (wr_kind == `PRT_KIND_TTL) begin
                ttl_reg[wr_slot*8+:8] <= wb0 & TTL_M[wr_slot*8+:8];
            end else if (wr_kind == `PRT_KIND_ODRN) begin
                odrn_reg[wr_slot*8+:8] <= wb0 & ODRN_M[wr_slot*8+:8];
            end else if (wr_kind == `PRT_KIND_ASEL) begin
                pin_digital_analog_select_reg[wr_slot*8+:8] <=
                    wb0 & ASEL_M[wr_slot*8+:8];
            end else if (wr_kind == `PRT_KIND_MISC) begin
                if (wr_slot == `PRT_MISC_CONV) begin
                    converter_pin_config_reg[7:0] <= wb0;
                end else if (wr_slot == `PRT_MISC_REDIR) begin
                    peripheral_pin_redirect_reg <= wb0;
                end
            end
        end
        if (aresetn && wr_go && wr_ok && wstrb_reg[1] && wr_kind == `PRT_KIND_MISC &&
            wr_slot == `PRT_MISC_CONV) begin
            converter_pin_config_reg[11:8] <= wb1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PRT_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            if (map_ok(s_axi_araddr)) begin
                rdata_reg <= rd_val(s_axi_araddr);
                rresp_reg <= `PRT_RESP_OKAY;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= `PRT_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External reset pin and redirection

    // Reset pin has no port function; it only raises a reset request
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_reset_reg <= 1'b0;
        end else begin
            ext_reset_reg <= ~reset_pin_n;
        end
    end

    assign ext_reset_req = ext_reset_reg;
    assign redirect_sel = peripheral_pin_redirect_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pad control per slot

    wire [127:0] ana_vec;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : slot
            if (g == 2) begin : conv_lo
                assign ana_vec[g*8+:8] = converter_pin_config_reg[7:0];
            end else if (g == 15) begin : conv_hi
                assign ana_vec[g*8+:8] = {4'h0, converter_pin_config_reg[11:8]};
            end else begin : asel
                assign ana_vec[g*8+:8] = pin_digital_analog_select_reg[g*8+:8];
            end
            prt_pin_cell #(
                .IO_M(IO_M[g*8+:8]),
                .OUT_M(OUT_M[g*8+:8]),
                .PULL_M(PULL_M[g*8+:8]),
                .TTL_M(TTL_M[g*8+:8]),
                .ODRN_M(ODRN_M[g*8+:8])
            ) u_cell (
                .data(data_reg[g*8+:8]),
                .mode(mode_reg[g*8+:8]),
                .pull(pull_reg[g*8+:8]),
                .ttl(ttl_reg[g*8+:8]),
                .odrn(odrn_reg[g*8+:8]),
                .ana(ana_vec[g*8+:8]),
                .pad_out(pin_out[g*8+:8]),
                .pad_oe_n(pin_oe_n[g*8+:8]),
                .pullup_en(pin_pullup_en[g*8+:8]),
                .ttl_en(pin_ttl_en[g*8+:8]),
                .analog_en(pin_analog_en[g*8+:8])
            );
        end
    endgenerate

endmodule

//--- prt_port_cfg_assertions.sv
// Checker for the port configuration block: pad controls and reset pin.
// Assumes it is bound to prt_port_cfg and sees only its ports.
`timescale 1ns/1ps
module prt_port_cfg_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire [127:0] pin_oe_n,
    input wire [127:0] pin_pullup_en,
    input wire [127:0] pin_ttl_en,
    input wire [127:0] pin_analog_en,
    input wire reset_pin_n,
    input wire ext_reset_req,
    input wire [7:0] redirect_sel
);
localparam [127:0] TTL_OK = 128'h000c0000_00000000_00003818_0000fb1a;
localparam [127:0] DRV_OK = 128'h0fdf0101_03010000_ffff3f3f_03ffff7f;
localparam [127:0] ANA_RST = 128'h0f800001_00010000_00000000_00ff000c;
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
property p_pull_in; !(|(pin_pullup_en & ~pin_oe_n)); endproperty
a_pull_in: assert property (p_pull_in) else $error("pull-up on a driven pin");
property p_p6_low; pin_pullup_en[51:48] == 4'h0; endproperty
a_p6_low: assert property (p_p6_low) else $error("pull-up on port 6 low bits");
property p_ttl_map; (pin_ttl_en & ~TTL_OK) == 128'h0; endproperty
a_ttl_map: assert property (p_ttl_map) else $error("threshold on wrong pin");
property p_abs_drv; (~pin_oe_n & ~DRV_OK) == 128'h0; endproperty
a_abs_drv: assert property (p_abs_drv) else $error("absent or input pin driven");
property p_p13_out; !pin_oe_n[104]; endproperty
a_p13_out: assert property (p_p13_out) else $error("port 13 bit 0 not driven");
property p_ext_rst; $past(aresetn) |-> ext_reset_req == !$past(reset_pin_n); endproperty
a_ext_rst: assert property (p_ext_rst) else $error("reset request mismatch");
property p_redir; !$stable(redirect_sel) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
a_redir: assert property (p_redir) else $error("redirect moved without write");
property p_rst_state;
    $rose(aresetn) |-> pin_oe_n == ~128'h00000100_00000000_00000000_00000000
        && pin_analog_en == ANA_RST && pin_pullup_en == 128'h0 && pin_ttl_en == 128'h0;
endproperty
a_rst_state: assert property (p_rst_state) else $error("bad pad state after reset");
endmodule
bind prt_port_cfg prt_port_cfg_assertions prt_port_cfg_assertions_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .pin_ttl_en(pin_ttl_en), .pin_analog_en(pin_analog_en),
    .reset_pin_n(reset_pin_n), .ext_reset_req(ext_reset_req), .redirect_sel(redirect_sel));

//--- prt_port_cfg_tb.sv
// Self-checking bench for the port configuration block over AXI4-Lite.
// Assumes the board model resolves the pads; all full-word writes.
`timescale 1ns/1ps
module prt_port_cfg_tb;
localparam [127:0] IO_W = 128'h0fdf0001_03010000_ffff3f3f_03ffff7f;
localparam [1:0] OK = 2'h0;
localparam [1:0] ER = 2'h2;
reg aclk = 1'h0;
reg aresetn = 1'h0;
reg rst_pin_n = 1'h1;
reg [11:0] awaddr = 12'h000;
reg [11:0] araddr = 12'h000;
reg [31:0] wdata = 32'h0;
reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
reg [127:0] ext_lvl = {128{1'h1}};
wire awready, wready, bvalid, arready, rvalid, ext_rst;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [7:0] redir;
wire [127:0] pin_in, pin_out, oe_n, pull_en, ttl_en, ana_en;
integer errors = 0;
integer checked = 0;
integer cyc = 0;
integer i;
reg [19:0] opt [0:10];
reg [11:0] ad;
reg [7:0] m;
always #10 aclk = ~aclk;
prt_port_cfg prt_port_cfg_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_pullup_en(pull_en), .pin_ttl_en(ttl_en),
    .pin_analog_en(ana_en), .reset_pin_n(rst_pin_n), .ext_reset_req(ext_rst),
    .redirect_sel(redir));
prt_board_model prt_board_model_inst (.pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_pullup_en(pull_en), .ext_lvl(ext_lvl), .pin_in(pin_in));
////////////////////////////////////////////////////////////////////////////////
task results;
    begin
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
task chk(input string nm, input [127:0] seen, input [127:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
// Readies and answers are sampled mid-cycle, where they equal the edge values
task wr(input [11:0] a, input [31:0] d, input [1:0] r);
    reg ta, tw, done;
    reg [1:0] rs;
    begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        done = 1'h0;
        while (!done) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            done = (bvalid === 1'h1);
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (done) bready <= 1'h0;
        end
        @(negedge aclk);
        chk("bresp", rs, r);
    end
endtask
task rd(input [11:0] a, input [31:0] d, input [1:0] r);
    reg ta, done;
    reg [31:0] dat;
    reg [1:0] rs;
    begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        done = 1'h0;
        while (!done) begin
            @(negedge aclk);
            ta = arvalid & arready;
            done = (rvalid === 1'h1);
            dat = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            if (done) rready <= 1'h0;
        end
        @(negedge aclk);
        chk("rdata", dat, d);
        chk("rresp", rs, r);
    end
endtask
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
        errors = errors + 1;
        results;
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    opt[0] = {12'h098, 8'hf0};
    opt[1] = {12'h0c0, 8'h1a};
    opt[2] = {12'h0c4, 8'hfb};
    opt[3] = {12'h0d0, 8'h18};
    opt[4] = {12'h0d4, 8'h38};
    opt[5] = {12'h0f8, 8'h0c};
    opt[6] = {12'h100, 8'h1d};
    opt[7] = {12'h110, 8'h38};
    opt[8] = {12'h114, 8'h3d};
    opt[9] = {12'h11c, 8'h12};
    opt[10] = {12'h138, 8'h1c};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk("oe_n", oe_n, ~128'h00000100_00000000_00000000_00000000);
    chk("analog", ana_en, 128'h0f800001_00010000_00000000_00ff000c);
    rd(12'h040, 32'h7f, OK);
    rd(12'h180, 32'hfff, OK);
    wr(12'h180, 32'h0f0, OK);
    chk("adc pins", {ana_en[127:120], ana_en[23:16]}, 16'h00f0);
    wr(12'h148, 32'h0, ER);
    rd(12'h600, 32'h0, ER);
    wr(12'h180, 32'h0, OK);
    wr(12'h140, 32'h0, OK);
    wr(12'h168, 32'h0, OK);
    wr(12'h170, 32'h0, OK);
    wr(12'h178, 32'h0, OK);
    chk("analog", ana_en, 128'h0);
    for (i = 0; i < 16; i = i + 1) begin
        ad = 12'h040 + {i[9:0], 2'h0};
        m = IO_W[i*8 +: 8];
        wr(ad, 32'hff, (m == 8'h00) ? ER : OK);
        rd(ad, {24'h0, m}, (m == 8'h00) ? ER : OK);
        wr(ad, 32'h0, (m == 8'h00) ? ER : OK);
    end
    chk("oe_n", oe_n, ~(IO_W | 128'h00000100_00000000_00000000_00000000));
    rd(12'h1f0, 32'h1e, OK);
    wr(12'h034, 32'h1, OK);
    rd(12'h1f4, 32'h81, OK);
    wr(12'h004, 32'ha5, OK);
    wr(12'h044, 32'h0f, OK);
    chk("oe_n p1", oe_n[15:8], 8'h0f);
    chk("out p1", pin_out[15:8] & ~oe_n[15:8], 8'ha0);
    wr(12'h084, 32'hff, OK);
    chk("pull p1", pull_en[15:8], 8'h0f);
    wr(12'h104, 32'hff, OK);
    rd(12'h104, 32'hbf, OK);
    chk("od p1", oe_n[15:8], 8'haf);
    for (i = 0; i < 11; i = i + 1) begin
        wr(opt[i][19:8], 32'hff, OK);
        rd(opt[i][19:8], {24'h0, opt[i][7:0]}, OK);
    end
    chk("ttl", ttl_en, 128'h000c0000_00000000_00003818_0000fb1a);
    chk("pull p6", pull_en[55:48], 8'h00);
    wr(12'h058, 32'hff, OK);
    chk("pull p6", pull_en[55:48], 8'hf0);
    wr(12'h184, 32'h5a, OK);
    chk("redirect", redir, 8'h5a);
    rd(12'h184, 32'h5a, OK);
    @(posedge aclk);
    rst_pin_n <= 1'h0;
    repeat (2) @(negedge aclk);
    chk("ext reset", ext_rst, 1'h1);
    rd(12'h188, 32'h1, OK);
    results;
end
endmodule

//--- prt_regs.vh
// Constants for the port pin configuration block: offsets, masks, resets.
// Assumes one AXI4-Lite slave port; slot n of every 128-bit vector is port n.
`ifndef PRT_REGS_VH
`define PRT_REGS_VH

// Address: [11:9] zero, [8:6] register kind, [5:2] port slot
`define PRT_KIND_DATA 3'h0
`define PRT_KIND_MODE 3'h1
`define PRT_KIND_PULL 3'h2
`define PRT_KIND_TTL 3'h3
`define PRT_KIND_ODRN 3'h4
`define PRT_KIND_ASEL 3'h5
`define PRT_KIND_MISC 3'h6
`define PRT_KIND_PIN 3'h7
`define PRT_MISC_CONV 4'h0
`define PRT_MISC_REDIR 4'h1
`define PRT_MISC_STAT 4'h2

// Per-slot capability masks, slot 15 in the top byte
`define PRT_IO_MASK 128'h0fdf0001_03010000_ffff3f3f_03ffff7f
`define PRT_IN_MASK 128'h0000801e_00000000_00000000_00000000
`define PRT_OUT_MASK 128'h00000100_00000000_00000000_00000000
`define PRT_PULL_MASK 128'h00df0001_03010000_fff03f3f_0300ff7f
`define PRT_TTL_MASK 128'h000c0000_00000000_00003818_0000fb1a
`define PRT_ODRN_MASK 128'h001c0000_00000000_12003d38_0000bf1d
`define PRT_ASEL_MASK 128'h00800001_00010000_00000000_0000000c

`define PRT_CONV_RESET 12'hfff
`define PRT_REDIR_RESET 8'h00
`define PRT_RESP_OKAY 2'h0
`define PRT_RESP_SLVERR 2'h2

`endif
